// file: hw/power_bank_pkg.sv
package power_bank_pkg;

    // Clock
    localparam int CLK_HZ = 200_000_000;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER_COMMAND = 8'h13;
    localparam logic [7:0] IDX_PD_DISABLE_MASK = 8'h14;
    localparam logic [7:0] IDX_PIN_CONFIG_0_1 = 8'h15;
    localparam logic [7:0] IDX_PIN_CONFIG_2_3 = 8'h16;
    localparam logic [7:0] IDX_PIN_CONFIG_4_5 = 8'h17;

    // Reset values
    localparam logic [7:0] RST_POWER_COMMAND = 8'h00;
    localparam logic [7:0] RST_PD_DISABLE_MASK = 8'h00;
    localparam logic [7:0] RST_PIN_CONFIG = 8'h00;

    // power_command fields
    localparam int CMD_WAKE_BIT = 2;
    localparam int CMD_SHUTDOWN_BIT = 1;
    localparam int CMD_WDOG_BIT = 0;
    localparam logic [7:0] CMD_RW_MASK = 8'h07;

    // powerdown_disable_mask fields
    localparam int PD_CTRL_INPUT_BIT = 7;
    localparam int PD_CLK_OUT_BIT = 6;
    localparam int PD_BACKUP_CHG_BIT = 5;
    localparam int PD_CALENDAR_BIT = 4;
    localparam int PD_FAST_SERIAL_BIT = 3;
    localparam int PD_PWR_MGR_IF_BIT = 2;
    localparam int PD_CONVERTER_BIT = 1;
    localparam int PD_INPUT_PINS_BIT = 0;

    // Pin config nibble layout: wake-off, polarity, function[1:0]
    localparam int PIN_COUNT = 6;
    localparam int PIN_CTRL_COUNT = 3;
    localparam int PIN_WAKE_OFF_BIT = 3;
    localparam int PIN_POLARITY_BIT = 2;
    localparam int PIN_FUNC_LSB = 0;

    // Function select codes
    localparam logic [1:0] FUNC_SPECIAL = 2'h0;
    localparam logic [1:0] FUNC_INPUT = 2'h1;
    localparam logic [1:0] FUNC_OUT_ALT = 2'h2;
    localparam logic [1:0] FUNC_OUT_PP = 2'h3;

    // Wake request hold time after entering active mode
    localparam int WAKE_HOLD_SEC = 16;
    localparam logic [31:0] WAKE_HOLD_CYCLES = 32'(64'(WAKE_HOLD_SEC) * 64'(CLK_HZ));

    // AHB-Lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Power-down gating sequence
    typedef enum logic [2:0] {
        PD_IDLE = 3'b001,
        PD_WAIT_STEP = 3'b010,
        PD_APPLIED = 3'b100
    } pd_state_t;

endpackage : power_bank_pkg

// file: hw/pin_cfg_if.sv
`timescale 1ns/100ps
interface pin_cfg_if;
    logic [1:0] func;
    logic polarity;
    logic wake_off;
    logic analog_sel;
    logic comparator_sel;
    logic input_sel;
    logic reg_hw_ctrl_sel;
    logic od_out_sel;
    logic pp_out_sel;
    logic seq_out_sel;
    logic rail_switch_sel;
    logic active_high;
    logic supply_two;
    logic wake_allowed;

    modport bank (
        output func, polarity, wake_off,
        input analog_sel, comparator_sel, input_sel, reg_hw_ctrl_sel, od_out_sel,
        input pp_out_sel, seq_out_sel, rail_switch_sel, active_high, supply_two,
        input wake_allowed
    );

    modport decoder (
        input func, polarity, wake_off,
        output analog_sel, comparator_sel, input_sel, reg_hw_ctrl_sel, od_out_sel,
        output pp_out_sel, seq_out_sel, rail_switch_sel, active_high, supply_two,
        output wake_allowed
    );
endinterface : pin_cfg_if

// file: hw/pin_func_decode.sv
`timescale 1ns/100ps
module pin_func_decode #(
    parameter int PIN = 0
) (
    // Configuration in, decoded selects out
    pin_cfg_if.decoder cfg
);
    always_comb begin
        cfg.analog_sel = 1'b0;
        cfg.comparator_sel = 1'b0;
        cfg.input_sel = 1'b0;
        cfg.reg_hw_ctrl_sel = 1'b0;
        cfg.od_out_sel = 1'b0;
        cfg.pp_out_sel = 1'b0;
        cfg.seq_out_sel = 1'b0;
        cfg.rail_switch_sel = 1'b0;
        case (cfg.func)
            power_bank_pkg::FUNC_SPECIAL: begin
                if (PIN <= 2) begin
                    cfg.analog_sel = 1'b1;
                end else begin
                    cfg.rail_switch_sel = 1'b1;
                end
                cfg.comparator_sel = (PIN == 1);
            end
            power_bank_pkg::FUNC_INPUT: begin
                cfg.input_sel = 1'b1;
                cfg.reg_hw_ctrl_sel = (PIN == 1) || (PIN == 2);
            end
            power_bank_pkg::FUNC_OUT_ALT: begin
                // Pin 2 only has a sequencer-driven push-pull output here
                if (PIN == 2) begin
                    cfg.pp_out_sel = 1'b1;
                    cfg.seq_out_sel = 1'b1;
                end else begin
                    cfg.od_out_sel = 1'b1;
                end
            end
            power_bank_pkg::FUNC_OUT_PP: begin
                cfg.pp_out_sel = 1'b1;
            end
            default: begin
                cfg.input_sel = 1'b0;
            end
        endcase
    end

    assign cfg.active_high = cfg.polarity;
    assign cfg.supply_two = cfg.polarity;
    assign cfg.wake_allowed = ~cfg.wake_off;
endmodule : pin_func_decode

// file: hw/power_cmd_bank.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
module power_cmd_bank #(
    parameter logic [31:0] WAKE_CLEAR_CYCLES = power_bank_pkg::WAKE_HOLD_CYCLES,
    parameter int STEP_W = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Power mode status from the sequencer
    input wire logic mode_powerdown,
    input wire logic mode_active,
    input wire logic mode_reset,
    input wire logic [STEP_W-1:0] pd_disable_seq_step,
    input wire logic [STEP_W-1:0] seq_max_count,
    input wire logic seq_step_done,
    input wire logic [STEP_W-1:0] seq_step_id,
    // Commands to the sequencer and watchdog
    output logic wake_start,
    output logic shutdown_request,
    output logic watchdog_restart,
    // Power-down function enables
    output logic ctrl_inputs_enable,
    output logic slow_clock_output_enable,
    output logic backup_charger_enable,
    output logic calendar_update_enable,
    output logic fast_two_wire_host_if_enable,
    output logic power_mgr_if_enable,
    output logic converter_meas_enable,
    output logic input_pins_enable,
    // Regulator control inputs
    input wire logic [2:0] ctrl_input_level,
    output logic ctrl_input_change,
    // Pins 0 to 5
    input wire logic [5:0] pin_level,
    output logic [5:0] pin_wake_event,
    output logic [5:0] pin_active,
    output logic [5:0] pin_analog_sel,
    output logic [5:0] pin_comparator_sel,
    output logic [5:0] pin_input_sel,
    output logic [5:0] pin_reg_hw_ctrl_sel,
    output logic [5:0] pin_od_out_sel,
    output logic [5:0] pin_pp_out_sel,
    output logic [5:0] pin_seq_out_sel,
    output logic [5:0] pin_rail_switch_sel,
    output logic [5:0] pin_supply_two
);
    localparam int NP = power_bank_pkg::PIN_COUNT;

    function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] target);
        idx_hit = (idx == target);
    endfunction : idx_hit

    // Bus state
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_idx_q;
    logic [31:0] hrdata_q;
    logic [7:0] addr_idx;
    logic addr_phase;

    // Registers
    logic [7:0] cmd_q;
    logic [7:0] mask_q;
    logic [7:0] pin01_q;
    logic [7:0] pin23_q;
    logic [7:0] pin45_q;
    logic [31:0] wake_cnt_q;
    logic wake_start_q;
    logic wdog_restart_q;
    logic mode_reset_q;

    // Power-down gating
    power_bank_pkg::pd_state_t pd_state_q;
    logic pd_apply;
    logic step_deferred;

    // Pin and control input tracking
    logic [2:0] ctrl_seen_q;
    logic ctrl_change_q;
    logic [5:0] pin_seen_q;
    logic [5:0] pin_wake_q;
    logic [5:0] pin_now_active;
    logic [5:0] pin_is_input;
    logic [5:0] pin_wake_ok;
    logic [23:0] pin_cfg_all;

    // Write strobes in data phase
    logic wr_cmd;
    logic wr_mask;
    logic wr_pin01;
    logic wr_pin23;
    logic wr_pin45;
    logic wake_clear;
    logic reset_entry;

    assign addr_idx = haddr[9:2];
    assign addr_phase = hsel && hready && (htrans == power_bank_pkg::HTRANS_NONSEQ);

    // Zero wait states; reads sampled in the address phase
    assign hreadyout = 1'b1;
    assign hresp = power_bank_pkg::HRESP_OKAY;
    assign hrdata = hrdata_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_idx_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_phase && hwrite;
            rd_pend_q <= addr_phase && !hwrite;
            addr_idx_q <= addr_idx;
        end
    end

    function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] cmd,
                                            input logic [7:0] mask, input logic [7:0] p01,
                                            input logic [7:0] p23, input logic [7:0] p45);
        reg_read = 8'h00;
        if (idx_hit(idx, power_bank_pkg::IDX_POWER_COMMAND)) begin
            reg_read = cmd;
        end else if (idx_hit(idx, power_bank_pkg::IDX_PD_DISABLE_MASK)) begin
            reg_read = mask;
        end else if (idx_hit(idx, power_bank_pkg::IDX_PIN_CONFIG_0_1)) begin
            reg_read = p01;
        end else if (idx_hit(idx, power_bank_pkg::IDX_PIN_CONFIG_2_3)) begin
            reg_read = p23;
        end else if (idx_hit(idx, power_bank_pkg::IDX_PIN_CONFIG_4_5)) begin
            reg_read = p45;
        end
    endfunction : reg_read

    // Unmapped indices read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata_q <= {24'h00_0000, reg_read(addr_idx, cmd_q, mask_q, pin01_q, pin23_q,
                                               pin45_q)};
        end
    end

    assign wr_cmd = wr_pend_q && idx_hit(addr_idx_q, power_bank_pkg::IDX_POWER_COMMAND);
    assign wr_mask = wr_pend_q && idx_hit(addr_idx_q, power_bank_pkg::IDX_PD_DISABLE_MASK);
    assign wr_pin01 = wr_pend_q && idx_hit(addr_idx_q, power_bank_pkg::IDX_PIN_CONFIG_0_1);
    assign wr_pin23 = wr_pend_q && idx_hit(addr_idx_q, power_bank_pkg::IDX_PIN_CONFIG_2_3);
    assign wr_pin45 = wr_pend_q && idx_hit(addr_idx_q, power_bank_pkg::IDX_PIN_CONFIG_4_5);

    // Plain read-write registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_q <= power_bank_pkg::RST_PD_DISABLE_MASK;
            pin01_q <= power_bank_pkg::RST_PIN_CONFIG;
            pin23_q <= power_bank_pkg::RST_PIN_CONFIG;
            pin45_q <= power_bank_pkg::RST_PIN_CONFIG;
        end else begin
            if (wr_mask) begin
                mask_q <= hwdata[7:0];
            end
            if (wr_pin01) begin
                pin01_q <= hwdata[7:0];
            end
            if (wr_pin23) begin
                pin23_q <= hwdata[7:0];
            end
            if (wr_pin45) begin
                pin45_q <= hwdata[7:0];
            end
        end
    end

    // Wake hold counter runs only while the bit is set in active mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_cnt_q <= 32'h0000_0000;
        end else if (cmd_q[power_bank_pkg::CMD_WAKE_BIT] && mode_active && !wake_clear) begin
            wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
        end else begin
            wake_cnt_q <= 32'h0000_0000;
        end
    end

    assign wake_clear = cmd_q[power_bank_pkg::CMD_WAKE_BIT] && mode_active
                        && (wake_cnt_q == WAKE_CLEAR_CYCLES - 32'h0000_0001);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reset_q <= 1'b0;
        end else begin
            mode_reset_q <= mode_reset;
        end
    end

    assign reset_entry = mode_reset && !mode_reset_q;

    // Command bits: writing 0 does nothing, a new set wins over a clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_q <= power_bank_pkg::RST_POWER_COMMAND;
        end else begin
            if (wr_cmd && hwdata[power_bank_pkg::CMD_WAKE_BIT]) begin
                cmd_q[power_bank_pkg::CMD_WAKE_BIT] <= 1'b1;
            end else if (wake_clear) begin
                cmd_q[power_bank_pkg::CMD_WAKE_BIT] <= 1'b0;
            end
            if (wr_cmd && hwdata[power_bank_pkg::CMD_SHUTDOWN_BIT]) begin
                cmd_q[power_bank_pkg::CMD_SHUTDOWN_BIT] <= 1'b1;
            end else if (reset_entry) begin
                cmd_q[power_bank_pkg::CMD_SHUTDOWN_BIT] <= 1'b0;
            end
            if (wr_cmd && hwdata[power_bank_pkg::CMD_WDOG_BIT]) begin
                cmd_q[power_bank_pkg::CMD_WDOG_BIT] <= 1'b1;
            end else begin
                cmd_q[power_bank_pkg::CMD_WDOG_BIT] <= 1'b0;
            end
        end
    end

    // One-cycle command pulses
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_start_q <= 1'b0;
            wdog_restart_q <= 1'b0;
        end else begin
            wake_start_q <= wr_cmd && hwdata[power_bank_pkg::CMD_WAKE_BIT]
                            && mode_powerdown;
            wdog_restart_q <= wr_cmd && hwdata[power_bank_pkg::CMD_WDOG_BIT];
        end
    end

    assign wake_start = wake_start_q;
    assign watchdog_restart = wdog_restart_q;
    assign shutdown_request = cmd_q[power_bank_pkg::CMD_SHUTDOWN_BIT];

    // Gating is deferred to a sequencer step only for a step id from 2 up to seq_max_count
    assign step_deferred = (pd_disable_seq_step > STEP_W'(1))
                           && (pd_disable_seq_step <= seq_max_count);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_state_q <= power_bank_pkg::PD_IDLE;
        end else begin
            case (pd_state_q)
                power_bank_pkg::PD_IDLE: begin
                    if (mode_powerdown) begin
                        pd_state_q <= step_deferred ? power_bank_pkg::PD_WAIT_STEP
                                                    : power_bank_pkg::PD_APPLIED;
                    end
                end
                power_bank_pkg::PD_WAIT_STEP: begin
                    if (!mode_powerdown) begin
                        pd_state_q <= power_bank_pkg::PD_IDLE;
                    end else if (seq_step_done && (seq_step_id == pd_disable_seq_step)) begin
                        pd_state_q <= power_bank_pkg::PD_APPLIED;
                    end
                end
                power_bank_pkg::PD_APPLIED: begin
                    if (!mode_powerdown) begin
                        pd_state_q <= power_bank_pkg::PD_IDLE;
                    end
                end
                default: begin
                    pd_state_q <= power_bank_pkg::PD_IDLE;
                end
            endcase
        end
    end

    assign pd_apply = (pd_state_q == power_bank_pkg::PD_APPLIED);

    assign ctrl_inputs_enable = !(pd_apply && mask_q[power_bank_pkg::PD_CTRL_INPUT_BIT]);
    assign slow_clock_output_enable = !(pd_apply
                                        && mask_q[power_bank_pkg::PD_CLK_OUT_BIT]);
    assign backup_charger_enable = !(pd_apply
                                     && mask_q[power_bank_pkg::PD_BACKUP_CHG_BIT]);
    assign calendar_update_enable = !(pd_apply
                                      && mask_q[power_bank_pkg::PD_CALENDAR_BIT]);
    assign fast_two_wire_host_if_enable = !(pd_apply
                                            && mask_q[power_bank_pkg::PD_FAST_SERIAL_BIT]);
    assign power_mgr_if_enable = !(pd_apply
                                   && mask_q[power_bank_pkg::PD_PWR_MGR_IF_BIT]);
    assign converter_meas_enable = !(pd_apply
                                     && mask_q[power_bank_pkg::PD_CONVERTER_BIT]);
    assign input_pins_enable = !(pd_apply && mask_q[power_bank_pkg::PD_INPUT_PINS_BIT]);

    // Frozen reference while gated, so a change hidden meanwhile shows on re-enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_seen_q <= 3'h0;
            ctrl_change_q <= 1'b0;
        end else if (ctrl_inputs_enable) begin
            ctrl_seen_q <= ctrl_input_level;
            ctrl_change_q <= (ctrl_input_level != ctrl_seen_q);
        end else begin
            ctrl_change_q <= 1'b0;
        end
    end

    assign ctrl_input_change = ctrl_change_q;

    // Per-pin decode
    assign pin_cfg_all = {pin45_q, pin23_q, pin01_q};

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_pin
            pin_cfg_if cfg_bus ();

            assign cfg_bus.func = pin_cfg_all[gi*4+power_bank_pkg::PIN_FUNC_LSB +: 2];
            assign cfg_bus.polarity = pin_cfg_all[gi*4+power_bank_pkg::PIN_POLARITY_BIT];
            assign cfg_bus.wake_off = pin_cfg_all[gi*4+power_bank_pkg::PIN_WAKE_OFF_BIT];

            pin_func_decode #(
                .PIN(gi)
            ) u_decode (
                .cfg(cfg_bus.decoder)
            );

            assign pin_analog_sel[gi] = cfg_bus.analog_sel;
            assign pin_comparator_sel[gi] = cfg_bus.comparator_sel;
            assign pin_is_input[gi] = cfg_bus.input_sel;
            assign pin_input_sel[gi] = cfg_bus.input_sel && input_pins_enable;
            assign pin_reg_hw_ctrl_sel[gi] = cfg_bus.reg_hw_ctrl_sel;
            assign pin_od_out_sel[gi] = cfg_bus.od_out_sel;
            assign pin_pp_out_sel[gi] = cfg_bus.pp_out_sel;
            assign pin_seq_out_sel[gi] = cfg_bus.seq_out_sel;
            assign pin_rail_switch_sel[gi] = cfg_bus.rail_switch_sel;
            assign pin_supply_two[gi] = cfg_bus.supply_two;
            assign pin_wake_ok[gi] = cfg_bus.wake_allowed;
            assign pin_now_active[gi] = cfg_bus.active_high ? pin_level[gi]
                                                            : !pin_level[gi];
        end
    endgenerate

    // Wake events on a passive-to-active edge of an enabled input pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_seen_q <= 6'h00;
            pin_wake_q <= 6'h00;
        end else if (input_pins_enable) begin
            pin_seen_q <= pin_now_active & pin_is_input;
            pin_wake_q <= pin_now_active & ~pin_seen_q & pin_is_input
                          & pin_wake_ok;
        end else begin
            pin_wake_q <= 6'h00;
        end
    end

    assign pin_wake_event = pin_wake_q;
    assign pin_active = pin_seen_q;

endmodule : power_cmd_bank

// file: bench/seq_model.sv
`timescale 1ns/100ps
module seq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests
    input wire logic pd_req,
    input wire logic wake_start,
    input wire logic shutdown_request,
    input wire logic [4:0] pd_disable_seq_step,
    // Mode status
    output logic mode_powerdown,
    output logic mode_active,
    output logic mode_reset,
    output logic seq_step_done,
    output logic [4:0] seq_step_id
);
    logic [3:0] step_q;
    logic [2:0] down_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {mode_powerdown, mode_active, mode_reset} <= 3'h2;
        end else if (down_q == 3'h4) begin
            {mode_powerdown, mode_active, mode_reset} <= 3'h1;
        end else if (wake_start && mode_powerdown) begin
            {mode_powerdown, mode_active, mode_reset} <= 3'h2;
        end else if (pd_req && mode_active) begin
            {mode_powerdown, mode_active, mode_reset} <= 3'h4;
        end
    end
    // Reset mode is reached a few cycles after the request, never at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            down_q <= 3'h0;
        end else if (shutdown_request && down_q != 3'h4) begin
            down_q <= down_q + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n || !mode_powerdown) begin
            step_q <= 4'h0;
        end else if (step_q != 4'hf) begin
            step_q <= step_q + 4'h1;
        end
    end
    assign seq_step_done = (step_q == 4'h8);
    assign seq_step_id = pd_disable_seq_step;
endmodule : seq_model

// file: bench/bank_checker.sv
`timescale 1ns/100ps
module bank_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Status and commands
    input wire logic mode_powerdown,
    input wire logic mode_reset,
    input wire logic wake_start,
    input wire logic shutdown_request,
    input wire logic watchdog_restart,
    // Enables
    input wire logic slow_clock_output_enable,
    input wire logic backup_charger_enable,
    input wire logic calendar_update_enable,
    input wire logic fast_two_wire_host_if_enable,
    input wire logic power_mgr_if_enable,
    input wire logic converter_meas_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Gating releases one edge after leaving power-down
    sequence s_in_pd;
        mode_powerdown || $past(mode_powerdown);
    endsequence
    sequence s_reset_entry;
        $rose(mode_reset);
    endsequence
    property p_clk; !slow_clock_output_enable |-> s_in_pd; endproperty
    a_clk: assert property (p_clk) else $error("clock out off outside pd");
    property p_chg; !backup_charger_enable |-> s_in_pd; endproperty
    a_chg: assert property (p_chg) else $error("charger off outside pd");
    property p_cal; !calendar_update_enable |-> s_in_pd; endproperty
    a_cal: assert property (p_cal) else $error("calendar off outside pd");
    property p_fsi; !fast_two_wire_host_if_enable |-> s_in_pd; endproperty
    a_fsi: assert property (p_fsi) else $error("fast if off outside pd");
    property p_pmi; !power_mgr_if_enable |-> s_in_pd; endproperty
    a_pmi: assert property (p_pmi) else $error("pm if off outside pd");
    property p_cnv; !converter_meas_enable |-> s_in_pd; endproperty
    a_cnv: assert property (p_cnv) else $error("converter off outside pd");
    property p_wake; wake_start |-> $past(mode_powerdown) || $past(mode_powerdown, 2); endproperty
    a_wake: assert property (p_wake) else $error("wake outside pd");
    property p_sd_hold; shutdown_request && !mode_reset |=> shutdown_request; endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("shutdown dropped early");
    property p_sd_clr; s_reset_entry |=> !shutdown_request; endproperty
    a_sd_clr: assert property (p_sd_clr) else $error("shutdown not cleared");
    property p_wdog; watchdog_restart |=> !watchdog_restart; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog pulse too long");
endmodule : bank_checker

bind power_cmd_bank bank_checker i_chk (.*);

// file: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] CMD = power_bank_pkg::IDX_POWER_COMMAND;
    localparam logic [7:0] MSK = power_bank_pkg::IDX_PD_DISABLE_MASK;
    localparam logic [7:0] P01 = power_bank_pkg::IDX_PIN_CONFIG_0_1;
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, pd_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, ctrl_input_level;
    logic [4:0] pd_disable_seq_step, seq_max_count, seq_step_id;
    logic mode_powerdown, mode_active, mode_reset, seq_step_done;
    logic wake_start, shutdown_request, watchdog_restart, ctrl_input_change;
    logic ctrl_inputs_enable, slow_clock_output_enable, backup_charger_enable;
    logic calendar_update_enable, fast_two_wire_host_if_enable, power_mgr_if_enable;
    logic converter_meas_enable, input_pins_enable;
    logic [5:0] pin_level, pin_wake_event, pin_active, pin_analog_sel, pin_comparator_sel;
    logic [5:0] pin_input_sel, pin_reg_hw_ctrl_sel, pin_od_out_sel, pin_pp_out_sel;
    logic [5:0] pin_seq_out_sel, pin_rail_switch_sel, pin_supply_two;
    logic [1:0] seen;
    int n_errors, num_checks, nev, nci;
    wire [7:0] en = {ctrl_inputs_enable, slow_clock_output_enable, backup_charger_enable,
        calendar_update_enable, fast_two_wire_host_if_enable, power_mgr_if_enable,
        converter_meas_enable, input_pins_enable};

    assign hready = hreadyout;
    power_cmd_bank #(.WAKE_CLEAR_CYCLES(32'h14)) i_dut (.*);
    seq_model i_seq (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst_n) begin
            nev <= nev + int'(pin_wake_event[0]);
            nci <= nci + int'(ctrl_input_change);
            seen <= seen | {watchdog_restart, wake_start};
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
        output logic [7:0] rd);
        int n = 0;
        hsel <= 1'b1;
        htrans <= power_bank_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        rd = hrdata[7:0];
        if (n >= 50) n_errors++;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, idx, d, r);
        @(posedge clk);
    endtask : wr
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk(r, exp);
    endtask : rc

    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            rc(8'(MSK + i), 8'h00);
            wr(8'(MSK + i), 8'(8'h5a + i));
            rc(8'(MSK + i), 8'(8'h5a + i));
        end
        wr(8'h20, 8'hff);
        rc(8'h20, 8'h00);
        wr(CMD, 8'hf8);
        rc(CMD, 8'h00);
        $display("done regs");
    endtask : t_regs
    task automatic t_pins;
        for (int c = 0; c < 4; c++) begin
            wr(P01, 8'(c));
            chk(8'({pin_analog_sel[0], pin_input_sel[0], pin_od_out_sel[0], pin_pp_out_sel[0]}),
                8'(4'h8 >> c));
        end
        chk(8'({pin_comparator_sel[1], pin_reg_hw_ctrl_sel[1]}), 8'h02);
        wr(8'(P01 + 1), 8'h02);
        wr(8'(P01 + 2), 8'h00);
        chk(8'({pin_analog_sel[2], pin_seq_out_sel[2], pin_rail_switch_sel[5:3]}), 8'h0f);
        pin_level <= 6'h00;
        wr(P01, 8'h05);
        chk(8'(pin_supply_two[0]), 8'h01);
        pin_level <= 6'h01;
        repeat (3) @(posedge clk);
        chk(8'(nev), 8'h01);
        pin_level <= 6'h00;
        wr(P01, 8'h0d);
        pin_level <= 6'h01;
        repeat (3) @(posedge clk);
        chk(8'(nev), 8'h01);
        $display("done pins");
    endtask : t_pins
    task automatic t_wdog;
        wr(CMD, 8'h00);
        chk(8'(seen[1]), 8'h00);
        wr(CMD, 8'h01);
        repeat (2) @(posedge clk);
        chk(8'(seen[1]), 8'h01);
        rc(CMD, 8'h00);
        $display("done wdog");
    endtask : t_wdog
    task automatic t_gate(input logic [4:0] step);
        int n0;
        pd_disable_seq_step <= step;
        wr(MSK, 8'hff);
        pd_req <= 1'b1;
        @(posedge clk);
        pd_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk(en, step == 5'h00 ? 8'h00 : 8'hff);
        repeat (10) @(posedge clk);
        chk(en, 8'h00);
        n0 = nci;
        ctrl_input_level <= ctrl_input_level ^ 3'h7;
        repeat (3) @(posedge clk);
        chk(8'(nci - n0), 8'h00);
        wr(CMD, 8'h04);
        rc(CMD, 8'h04);
        repeat (2) @(posedge clk);
        chk(en, 8'hff);
        chk(8'({seen[0], mode_active}), 8'h03);
        chk(8'(nci - n0), 8'h01);
        repeat (25) @(posedge clk);
        rc(CMD, 8'h00);
        $display("done gate");
    endtask : t_gate
    task automatic t_shut;
        wr(CMD, 8'h02);
        rc(CMD, 8'h02);
        chk(8'(shutdown_request), 8'h01);
        repeat (8) @(posedge clk);
        chk(8'(mode_reset), 8'h01);
        rc(CMD, 8'h00);
        $display("done shut");
    endtask : t_shut
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    initial begin
        #20000;
        n_errors++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        {hsel, hwrite, pd_req, seen, nev, nci, n_errors, num_checks} = '0;
        {haddr, hwdata, htrans, ctrl_input_level, pd_disable_seq_step} = '0;
        hsize = 3'h2;
        seq_max_count = 5'h08;
        pin_level = 6'h3f;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_pins();
        t_wdog();
        t_gate(5'h00);
        t_gate(5'h05);
        t_shut();
        conclude();
    end
endmodule : tb_top
